// ===== verilog/acs_pkg.sv
// constants for the conversion status flag block
package acs_pkg;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_ONE_REG = 4'h1;
  localparam logic [3:0] ADDR_DATA = 4'h4;
  localparam logic [3:0] ADDR_GAIN = 4'h8;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CONTROL_ONE_REG_RESET = 8'h02;
  localparam logic [23:0] GAIN_RESET = 24'h800000;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [23:0] GAIN_MAX = 24'hFFFFFF;
  localparam int ST_SYS_OVR = 7;
  localparam int ST_RATE_HI = 6;
  localparam int ST_RATE_LO = 4;
  localparam int ST_OVER = 3;
  localparam int ST_UNDER = 2;
  localparam int ST_BUSY = 1;
  localparam int ST_READY = 0;
  localparam int C1_LINE_FREQ = 7;
  localparam int C1_UNIPOLAR = 6;
  localparam int C1_EXT_CLK = 5;
  localparam int C1_REF_BUF = 4;
  localparam int C1_SIG_BUF = 3;
  localparam int C1_OFFSET_FMT = 2;
  localparam int C1_SINGLE_CYCLE = 1;
  localparam logic signed [17:0] UNI_MAX = 18'sh0FFFF;
  localparam logic signed [17:0] UNI_MIN = 18'sh00000;
  localparam logic signed [17:0] BIP_MAX = 18'sh07FFF;
  localparam logic signed [17:0] BIP_MIN = 18'sh38000;
endpackage

// ===== verilog/acs_result_if.sv
// result and calibration hand-off between capture modules and the register bank
`timescale 1ns/1ps
interface acs_result_if;
  logic result_load;
  logic [15:0] result_code;
  logic result_over;
  logic result_under;
  logic gain_load;
  logic [23:0] gain_value;
  logic gain_over;
  modport result_src (output result_load, output result_code, output result_over,
    output result_under);
  modport gain_src (output gain_load, output gain_value, output gain_over);
  modport sink (input result_load, input result_code, input result_over,
    input result_under, input gain_load, input gain_value, input gain_over);
endinterface

// ===== verilog/acs_result_clamp.sv
// clamps a raw conversion value and flags over and under range
`timescale 1ns/1ps
module acs_result_clamp (
  input wire logic clk,
  input wire logic reset,
  input wire logic raw_valid,
  input wire logic signed [17:0] raw_value,
  input wire logic unipolar,
  input wire logic offset_fmt,
  acs_result_if.result_src res
);
  logic signed [17:0] hi;
  logic signed [17:0] lo;
  logic over;
  logic under;
  logic signed [17:0] clipped;
  logic [15:0] code;

  always_comb begin
    hi = unipolar ? acs_pkg::UNI_MAX : acs_pkg::BIP_MAX;
    lo = unipolar ? acs_pkg::UNI_MIN : acs_pkg::BIP_MIN;
    over = raw_value > hi;
    under = raw_value < lo;
    clipped = over ? hi : (under ? lo : raw_value);
    code = clipped[15:0];
    if (!unipolar && offset_fmt) begin
      code[15] = ~clipped[15];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      res.result_load <= 1'b0;
      res.result_code <= acs_pkg::DATA_RESET;
      res.result_over <= 1'b0;
      res.result_under <= 1'b0;
    end else begin
      res.result_load <= raw_valid;
      if (raw_valid) begin
        res.result_over <= over;
        res.result_under <= under;
        res.result_code <= code;
      end
    end
  end
endmodule

// ===== verilog/acs_gain_clamp.sv
// limits a system gain calibration result to the largest coefficient
`timescale 1ns/1ps
module acs_gain_clamp (
  input wire logic clk,
  input wire logic reset,
  input wire logic gain_valid,
  input wire logic [24:0] gain_raw,
  acs_result_if.gain_src gain
);
  always_ff @(posedge clk) begin
    if (reset) begin
      gain.gain_load <= 1'b0;
      gain.gain_value <= acs_pkg::GAIN_RESET;
      gain.gain_over <= 1'b0;
    end else begin
      gain.gain_load <= gain_valid;
      if (gain_valid) begin
        gain.gain_value <= gain_raw[24] ? acs_pkg::GAIN_MAX : gain_raw[23:0];
        gain.gain_over <= gain_raw[24];
      end
    end
  end
endmodule

// ===== verilog/acs_status_bank.sv
// conversion status, control one, data and system gain registers
`timescale 1ns/1ps
module acs_status_bank (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  output logic [23:0] reg_rdata,
  output logic reg_rd_done,
  input wire logic conv_start,
  input wire logic mod_busy,
  input wire logic [2:0] rate_code,
  input wire logic raw_valid,
  input wire logic signed [17:0] raw_value,
  input wire logic cal_done,
  input wire logic gain_valid,
  input wire logic [24:0] gain_raw,
  output logic [7:0] conversion_status,
  output logic [7:0] control_one_reg,
  output logic [15:0] data_result,
  output logic [23:0] system_gain_coefficient,
  output logic ready_flag,
  output logic line_freq_50,
  output logic unipolar_range,
  output logic ext_clock_sel,
  output logic ref_buf_en,
  output logic sig_buf_en,
  output logic offset_binary,
  output logic single_cycle
);
  typedef enum logic [3:0] {
    RDY_EMPTY = 4'b0001,
    RDY_FRESH = 4'b0010,
    RDY_READ_EARLY = 4'b0100,
    RDY_STARTED = 4'b1000
  } acs_rdy_state_t;

  acs_rdy_state_t rdy_state;
  acs_rdy_state_t next_rdy_state;
  acs_result_if link ();
  logic sys_gain_overrange;
  logic [2:0] rate_field;
  logic overrange_flag;
  logic underrange_flag;
  logic modulator_busy_flag;
  logic [7:0] ctrl_one;
  logic [15:0] data_reg;
  logic [23:0] gain_reg;
  logic rd_pending;
  logic [3:0] rd_addr;
  logic data_read_done;

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] target);
    hit = (addr == target);
  endfunction

  acs_result_clamp u_clamp (
    .clk(clk),
    .reset(reset),
    .raw_valid(raw_valid),
    .raw_value(raw_value),
    .unipolar(ctrl_one[acs_pkg::C1_UNIPOLAR]),
    .offset_fmt(ctrl_one[acs_pkg::C1_OFFSET_FMT]),
    .res(link.result_src)
  );

  acs_gain_clamp u_gain (
    .clk(clk),
    .reset(reset),
    .gain_valid(gain_valid),
    .gain_raw(gain_raw),
    .gain(link.gain_src)
  );

  // register read pipeline
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_pending <= 1'b0;
      rd_addr <= acs_pkg::ADDR_STATUS;
    end else begin
      rd_pending <= reg_rd;
      if (reg_rd) begin
        rd_addr <= reg_addr;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 24'h000000;
      reg_rd_done <= 1'b0;
    end else begin
      reg_rd_done <= reg_rd;
      if (reg_rd) begin
        if (hit(reg_addr, acs_pkg::ADDR_STATUS)) begin
          reg_rdata <= {16'h0000, conversion_status};
        end else if (hit(reg_addr, acs_pkg::ADDR_CONTROL_ONE_REG)) begin
          reg_rdata <= {16'h0000, ctrl_one};
        end else if (hit(reg_addr, acs_pkg::ADDR_DATA)) begin
          reg_rdata <= {8'h00, data_reg};
        end else if (hit(reg_addr, acs_pkg::ADDR_GAIN)) begin
          reg_rdata <= gain_reg;
        end else begin
          reg_rdata <= 24'h000000;
        end
      end
    end
  end

  assign data_read_done = rd_pending && hit(rd_addr, acs_pkg::ADDR_DATA);

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_one <= acs_pkg::CONTROL_ONE_REG_RESET;
    end else if (reg_wr && hit(reg_addr, acs_pkg::ADDR_CONTROL_ONE_REG)) begin
      ctrl_one <= {reg_wdata[7:1], 1'b0};
    end
  end

  // calibration result wins over a host write
  always_ff @(posedge clk) begin
    if (reset) begin
      gain_reg <= acs_pkg::GAIN_RESET;
    end else if (link.gain_load) begin
      gain_reg <= link.gain_value;
    end else if (reg_wr && hit(reg_addr, acs_pkg::ADDR_GAIN)) begin
      gain_reg <= reg_wdata;
    end
  end

  // overrange of last system gain cal
  always_ff @(posedge clk) begin
    if (reset) begin
      sys_gain_overrange <= 1'b0;
    end else if (link.gain_load) begin
      sys_gain_overrange <= link.gain_over;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      data_reg <= acs_pkg::DATA_RESET;
      overrange_flag <= 1'b0;
      underrange_flag <= 1'b0;
    end else if (link.result_load) begin
      data_reg <= link.result_code;
      overrange_flag <= link.result_over;
      underrange_flag <= link.result_under;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rate_field <= 3'h0;
    end else if (raw_valid || cal_done) begin
      rate_field <= rate_code;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      modulator_busy_flag <= 1'b0;
    end else begin
      modulator_busy_flag <= mod_busy;
    end
  end

  // ready tracking
  always_comb begin
    next_rdy_state = rdy_state;
    unique case (rdy_state)
      RDY_EMPTY: begin
        next_rdy_state = RDY_EMPTY;
      end
      RDY_FRESH: begin
        if (conv_start) begin
          next_rdy_state = RDY_STARTED;
        end else if (data_read_done) begin
          next_rdy_state = RDY_READ_EARLY;
        end
      end
      RDY_READ_EARLY: begin
        if (conv_start) begin
          next_rdy_state = RDY_EMPTY;
        end
      end
      RDY_STARTED: begin
        if (data_read_done) begin
          next_rdy_state = RDY_EMPTY;
        end
      end
      default: begin
        next_rdy_state = RDY_EMPTY;
      end
    endcase
    if (link.result_load) begin
      next_rdy_state = RDY_FRESH;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdy_state <= RDY_EMPTY;
    end else begin
      rdy_state <= next_rdy_state;
    end
  end

  always_comb begin
    conversion_status = acs_pkg::STATUS_RESET;
    conversion_status[acs_pkg::ST_SYS_OVR] = sys_gain_overrange;
    conversion_status[acs_pkg::ST_RATE_HI:acs_pkg::ST_RATE_LO] = rate_field;
    conversion_status[acs_pkg::ST_OVER] = overrange_flag;
    conversion_status[acs_pkg::ST_UNDER] = underrange_flag;
    conversion_status[acs_pkg::ST_BUSY] = modulator_busy_flag;
    conversion_status[acs_pkg::ST_READY] = (rdy_state != RDY_EMPTY);
  end

  assign ready_flag = conversion_status[acs_pkg::ST_READY];
  assign control_one_reg = ctrl_one;
  assign data_result = data_reg;
  assign system_gain_coefficient = gain_reg;
  assign line_freq_50 = ctrl_one[acs_pkg::C1_LINE_FREQ];
  assign unipolar_range = ctrl_one[acs_pkg::C1_UNIPOLAR];
  assign ext_clock_sel = ctrl_one[acs_pkg::C1_EXT_CLK];
  assign ref_buf_en = ctrl_one[acs_pkg::C1_REF_BUF];
  assign sig_buf_en = ctrl_one[acs_pkg::C1_SIG_BUF];
  assign offset_binary = ctrl_one[acs_pkg::C1_OFFSET_FMT];
  assign single_cycle = ctrl_one[acs_pkg::C1_SINGLE_CYCLE];
endmodule

// ===== verif/acs_host_model.sv
// serial host model issuing register accesses
`timescale 1ns/1ps
module acs_host_model (
  input wire logic clk,
  input wire logic cmd_rd,
  input wire logic cmd_wr,
  input wire logic [3:0] cmd_addr,
  input wire logic [23:0] cmd_wdata,
  input wire logic auto_rd,
  input wire logic ready_flag,
  output logic reg_rd,
  output logic reg_wr,
  output logic [3:0] reg_addr,
  output logic [23:0] reg_wdata
);
  logic ready_q;
  logic fire;
  initial begin
    {reg_rd, reg_wr, reg_addr, reg_wdata, ready_q} = '0;
    forever begin
      @(posedge clk);
      fire = auto_rd && ready_flag && !ready_q;
      ready_q = ready_flag;
      reg_rd <= cmd_rd || fire;
      reg_wr <= cmd_wr;
      reg_addr <= fire ? acs_pkg::ADDR_DATA : cmd_addr;
      reg_wdata <= cmd_wr ? cmd_wdata : ~reg_wdata;
    end
  end
endmodule

// ===== verif/acs_status_bank_props.sv
// assertions on the status bank ports
`timescale 1ns/1ps
module acs_status_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic mod_busy,
  input wire logic [2:0] rate_code,
  input wire logic raw_valid,
  input wire logic signed [17:0] raw_value,
  input wire logic gain_valid,
  input wire logic [24:0] gain_raw,
  input wire logic [7:0] conversion_status,
  input wire logic [7:0] control_one_reg,
  input wire logic [15:0] data_result,
  input wire logic [23:0] system_gain_coefficient,
  input wire logic ready_flag,
  input wire logic unipolar_range,
  input wire logic line_freq_50,
  input wire logic ext_clock_sel,
  input wire logic ref_buf_en,
  input wire logic sig_buf_en,
  input wire logic offset_binary,
  input wire logic single_cycle
);
  logic [6:0] wr_hi;
  assign wr_hi = reg_wdata[7:1];
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_gain; gain_valid && gain_raw[24] |-> ##2
    system_gain_coefficient == 24'hFFFFFF && conversion_status[7]; endproperty
  a_gain: assert property (p_gain) else $error("gain overrange not flagged");
  property p_rate; raw_valid |=> conversion_status[6:4] == $past(rate_code); endproperty
  a_rate: assert property (p_rate) else $error("rate field wrong");
  property p_over; raw_valid && unipolar_range && raw_value > acs_pkg::UNI_MAX |-> ##2
    conversion_status[3] && data_result == 16'hFFFF; endproperty
  a_over: assert property (p_over) else $error("overrange not clipped");
  property p_under; raw_valid && unipolar_range && raw_value < acs_pkg::UNI_MIN |-> ##2
    conversion_status[2] && data_result == 16'h0000; endproperty
  a_under: assert property (p_under) else $error("underrange not clipped");
  property p_busy; mod_busy |=> conversion_status[1]; endproperty
  a_busy: assert property (p_busy) else $error("busy bit low");
  property p_idle; !mod_busy |=> !conversion_status[1]; endproperty
  a_idle: assert property (p_idle) else $error("busy bit high");
  property p_ready; raw_valid |-> ##2 ready_flag && conversion_status[0]; endproperty
  a_ready: assert property (p_ready) else $error("ready not set");
  property p_rst; $fell(reset) |-> conversion_status == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("status not zero");
  property p_ctrl; reg_wr && reg_addr == acs_pkg::ADDR_CONTROL_ONE_REG |=>
    control_one_reg[7:1] == $past(wr_hi); endproperty
  a_ctrl: assert property (p_ctrl) else $error("control byte not written");
  property p_ctrl_bits; {line_freq_50, unipolar_range, ext_clock_sel, ref_buf_en, sig_buf_en,
    offset_binary, single_cycle} == control_one_reg[7:1]; endproperty
  a_ctrl_bits: assert property (p_ctrl_bits) else $error("control outputs wrong");
endmodule
bind acs_status_bank acs_status_props i_props (.clk(clk), .reset(reset), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .mod_busy(mod_busy), .rate_code(rate_code),
  .raw_valid(raw_valid), .raw_value(raw_value), .gain_valid(gain_valid), .gain_raw(gain_raw),
  .conversion_status(conversion_status), .control_one_reg(control_one_reg),
  .data_result(data_result), .system_gain_coefficient(system_gain_coefficient),
  .ready_flag(ready_flag), .unipolar_range(unipolar_range), .line_freq_50(line_freq_50),
  .ext_clock_sel(ext_clock_sel), .ref_buf_en(ref_buf_en), .sig_buf_en(sig_buf_en),
  .offset_binary(offset_binary), .single_cycle(single_cycle));

// ===== verif/tb_top.sv
// self-checking bench for the status bank
`timescale 1ns/1ps
module tb_top;
  logic clk, reset, cmd_rd, cmd_wr, auto_rd, conv_start, mod_busy, raw_valid, cal_done;
  logic gain_valid, reg_wr, reg_rd, reg_rd_done, ready_flag;
  logic [3:0] cmd_addr, reg_addr;
  logic [23:0] cmd_wdata, reg_wdata, reg_rdata, gco, pst;
  logic [2:0] rate_code;
  logic signed [17:0] raw_value, raw;
  logic [24:0] gain_raw;
  logic [7:0] ctrl;
  logic [15:0] code;
  logic [23:0] exp_q[$];
  int n_errors, num_checks, cycles;
  acs_host_model i_host (.clk(clk), .cmd_rd(cmd_rd), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .auto_rd(auto_rd), .ready_flag(ready_flag), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  acs_status_bank i_dut (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_done(reg_rd_done), .conv_start(conv_start), .mod_busy(mod_busy),
    .rate_code(rate_code), .raw_valid(raw_valid), .raw_value(raw_value), .cal_done(cal_done),
    .gain_valid(gain_valid), .gain_raw(gain_raw), .conversion_status(), .control_one_reg(),
    .data_result(), .system_gain_coefficient(), .ready_flag(ready_flag), .line_freq_50(),
    .unipolar_range(), .ext_clock_sel(), .ref_buf_en(), .sig_buf_en(), .offset_binary(),
    .single_cycle());
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic acc(input logic wr, input logic [3:0] a, input logic [23:0] d, e);
    if (!wr)
      exp_q.push_back(e);
    cmd_wr <= wr;
    cmd_rd <= !wr;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic start(input logic [2:0] r);
    conv_start <= 1'b1;
    mod_busy <= 1'b1;
    rate_code <= r;
    @(posedge clk);
    conv_start <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic result(input logic signed [17:0] v);
    raw_value <= v;
    raw_valid <= 1'b1;
    mod_busy <= 1'b0;
    @(posedge clk);
    raw_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [23:0] st(input logic [2:0] r, input logic o, u, b, y);
    return {16'h0000, 1'b1, r, o, u, b, y};
  endfunction
  // result watcher
  always @(negedge clk) begin
    if (reg_rd_done === 1'b1) begin
      num_checks++;
      if (reg_rdata !== exp_q[0]) begin
        n_errors++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, reg_rdata, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    {reset, cmd_rd, cmd_wr, auto_rd, conv_start, mod_busy, raw_valid, cal_done} = 8'h80;
    {gain_valid, cmd_addr, cmd_wdata, rate_code, raw_value, gain_raw} = '0;
    void'($urandom(32'h557F));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    acc(0, acs_pkg::ADDR_STATUS, 0, 24'h000000);
    acc(1, acs_pkg::ADDR_STATUS, 24'h0000FF, 0);
    acc(0, acs_pkg::ADDR_STATUS, 0, 24'h000000);
    acc(0, acs_pkg::ADDR_CONTROL_ONE_REG, 0, {16'h0000, acs_pkg::CONTROL_ONE_REG_RESET});
    acc(0, 4'h3, 0, 24'h000000);
    ctrl = (8'($urandom()) | 8'h40) & 8'hFB;
    acc(1, acs_pkg::ADDR_CONTROL_ONE_REG, {16'h0000, ctrl}, 0);
    acc(0, acs_pkg::ADDR_CONTROL_ONE_REG, 0, {16'h0000, ctrl & 8'hFE});
    gco = 24'($urandom());
    acc(1, acs_pkg::ADDR_GAIN, gco, 0);
    acc(0, acs_pkg::ADDR_GAIN, 0, gco);
    rate_code <= 3'h5;
    gain_raw <= {1'b1, gco};
    gain_valid <= 1'b1;
    cal_done <= 1'b1;
    @(posedge clk);
    gain_valid <= 1'b0;
    cal_done <= 1'b0;
    repeat (3) @(posedge clk);
    acc(0, acs_pkg::ADDR_GAIN, 0, acs_pkg::GAIN_MAX);
    pst = st(3'h5, 0, 0, 0, 0);
    acc(0, acs_pkg::ADDR_STATUS, 0, pst);
    for (int i = 0; i < 3; i++) begin
      raw = (i == 0) ? 18'sh1FFFF : (i == 1) ? -18'sd5 : {2'b00, 16'($urandom())};
      code = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : raw[15:0];
      start(3'(i + 1));
      acc(0, acs_pkg::ADDR_STATUS, 0, (pst | 24'h2) & 24'hFFFFFE);
      result(raw);
      pst = st(3'(i + 1), i == 0, i == 1, 0, 1);
      acc(0, acs_pkg::ADDR_STATUS, 0, pst);
      acc(0, acs_pkg::ADDR_DATA, 0, {8'h00, code});
      acc(0, acs_pkg::ADDR_STATUS, 0, pst);
    end
    result(18'sh01234);
    start(3'h3);
    acc(0, acs_pkg::ADDR_STATUS, 0, st(3'h3, 0, 0, 1, 1));
    acc(0, acs_pkg::ADDR_DATA, 0, 24'h001234);
    acc(0, acs_pkg::ADDR_STATUS, 0, st(3'h3, 0, 0, 1, 0));
    auto_rd <= 1'b1;
    exp_q.push_back(24'h00ABCD);
    result(18'sh0ABCD);
    repeat (4) @(posedge clk);
    auto_rd <= 1'b0;
    acc(1, acs_pkg::ADDR_CONTROL_ONE_REG, 24'h000004, 0);
    result(18'sh0FFFF);
    acc(0, acs_pkg::ADDR_DATA, 0, 24'h00FFFF);
    acc(0, acs_pkg::ADDR_STATUS, 0, st(3'h3, 1, 0, 0, 1));
    stop_test();
  end
endmodule
